/* transcoder_pkg.sv */
package transcoder_pkg;

  // Channel count and serial word lengths
  localparam int unsigned NCH        = 4;
  localparam logic [3:0]  WORD_LONG  = 4'h8;
  localparam logic [3:0]  WORD_SHORT = 4'h4;
  localparam int unsigned WMAX       = 8;

  // Per-channel data path modes, taken from the mode pins
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_THRU64 = 2'h1;
  localparam logic [1:0] MODE_LOOP64 = 2'h2;
  localparam logic [1:0] MODE_LOOP32 = 2'h3;

  // Clock rates for reference by benches
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned LINK_PERIOD_NS = 320;

  // Left-justify a word so the first serial bit sits at the MSB
  function automatic logic [7:0] align_word(input logic [7:0] w, input logic wide);
    align_word = wide ? w : {w[3:0], 4'h0};
  endfunction : align_word

endpackage : transcoder_pkg

/* serial_port.sv */
`timescale 1ns/1ps

module serial_port
  import transcoder_pkg::*;
#(
  parameter bit IS_OUT = 1'b0
) (
  // System
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Framing control
  input  wire logic       sync_mode,
  input  wire logic       wide,
  input  wire logic [7:0] load_word,
  // Link pins
  input  wire logic       sclk_pin,
  input  wire logic       en_pin,
  input  wire logic       din_pin,
  // Results
  output logic [7:0]      word,
  output logic            done,
  output logic            dout,
  output logic            doe
);

  typedef struct packed {
    logic [2:0] ck_s;
    logic [1:0] en_s;
    logic [1:0] d_s;
    logic       en_last;
    logic       busy;
    logic       decide;
    logic       short_f;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] word;
    logic       done;
    logic       dout;
    logic       doe;
  } port_t;

  port_t      s_r;
  port_t      s_nxt;
  logic       rise;
  logic       fall;
  logic       en;
  logic [3:0] need;
  logic [7:0] aligned;

  // Edge finding on the synchronised link clock
  assign rise    = s_r.ck_s[1] & ~s_r.ck_s[2];
  assign fall    = ~s_r.ck_s[1] & s_r.ck_s[2];
  assign en      = s_r.en_s[1];
  assign need    = wide ? WORD_LONG : WORD_SHORT;
  assign aligned = align_word(load_word, wide);

  // Frame tracking, shifting and width detection
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ck_s = {s_r.ck_s[1:0], sclk_pin};
    s_nxt.en_s = {s_r.en_s[0], en_pin};
    s_nxt.d_s  = {s_r.d_s[0], din_pin};
    if (rise) begin
      s_nxt.en_last = en;
      if (en && !s_r.en_last) begin
        // Frame opens; sync mode never waits for a width decision
        s_nxt.busy    = 1'b1;
        s_nxt.decide  = !sync_mode;
        s_nxt.short_f = 1'b0;
        s_nxt.cnt     = 4'h0;
        if (IS_OUT) begin
          s_nxt.sh   = aligned;
          s_nxt.dout = aligned[7];
          s_nxt.doe  = 1'b1;
          s_nxt.cnt  = 4'h1;
        end
      end else if (s_r.busy) begin
        // One-bit enable means short frame, wider means long
        if (s_r.decide) begin
          s_nxt.decide  = 1'b0;
          s_nxt.short_f = !en;
        end
        if (IS_OUT) begin
          if (s_r.decide && !en) begin
            s_nxt.sh   = aligned;
            s_nxt.dout = aligned[7];
            s_nxt.cnt  = 4'h1;
          end else if (s_r.cnt < need) begin
            s_nxt.sh   = {s_r.sh[6:0], 1'b0};
            s_nxt.dout = s_r.sh[6];
            s_nxt.cnt  = s_r.cnt + 4'h1;
          end else begin
            s_nxt.busy = 1'b0;
            s_nxt.doe  = 1'b0;
            s_nxt.dout = 1'b0;
          end
        end
      end
    end
    // Input role samples on the falling link clock edge
    if (!IS_OUT && fall && s_r.busy) begin
      s_nxt.sh  = {s_r.sh[6:0], s_r.d_s[1]};
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_nxt.cnt == need + {3'h0, s_r.short_f}) begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.word = wide ? s_nxt.sh : {4'h0, s_nxt.sh[3:0]};
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign word = s_r.word;
  assign done = s_r.done;
  assign dout = s_r.dout;
  assign doe  = s_r.doe;

  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n) s_r.done |=> !s_r.done)
    else $error("start pulse longer than one cycle");
  AST_DONE_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.done |-> s_r.cnt == need + {3'h0, s_r.short_f})
    else $error("word completed with wrong bit count");
  AST_LONG_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (IS_OUT && rise && en && !s_r.en_last) |=> (s_r.doe && s_r.dout == $past(aligned[7])))
    else $error("result not loaded at enable rise");
  AST_SHORT_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (IS_OUT && rise && s_r.busy && s_r.decide && !en) |=> (s_r.short_f && s_r.cnt == 4'h1))
    else $error("short frame reload missing");
  AST_WIDTH_LONG: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && s_r.busy && s_r.decide && en) |=> !s_r.short_f)
    else $error("wide enable taken as short frame");
  AST_SYNC_LONG: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_mode && rise && en && !s_r.en_last) |=> !s_r.decide)
    else $error("sync mode waited for width decision");

endmodule : serial_port

/* adpcm_serial_data_delay_path.sv */
`timescale 1ns/1ps

// Summary of operation
// - Normal decoding returns each result two sample periods after input.
// - Pass-through forwards the 8-bit word unchanged, no coding calculation.
// - Pass-through and 64k loop-back outputs lag inputs by two sample periods.
// - 64k loop-back sends encoder input out through the decoder output.
// - 32k loop-back sends decoder input out through the encoder output.
// - 32k loop-back output lags its input by two sample periods.
// - A start pulse fires as soon as the last input bit arrives.
// - The start pulse captures the deserialised word as the next operand.
// - Long frame loads the result at the output enable rise.
// - Short frame loads the result one output clock after enable rise.
// - Enable one bit wide selects short frame, wider selects long frame.
// - Bypass modes still update the result on the start pulse.
// - Words are 8 bits at 64 kbps and 4 bits at 32 kbps.
// - Sync mode transfers bits right after enable rise, any width.
module adpcm_serial_data_delay_path
  import transcoder_pkg::*;
(
  // System
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Mode pins
  input  wire logic                     sync_mode,
  input  wire logic [NCH-1:0][1:0]      chan_mode,
  // Encoder input link
  input  wire logic [NCH/2-1:0]         enc_in_clk,
  input  wire logic [NCH-1:0]           enc_in_en,
  input  wire logic [NCH-1:0]           enc_in_data,
  // Decoder input link
  input  wire logic [NCH/2-1:0]         dec_in_clk,
  input  wire logic [NCH-1:0]           dec_in_en,
  input  wire logic [NCH-1:0]           dec_in_data,
  // Encoder output link
  input  wire logic [NCH/2-1:0]         enc_out_clk,
  input  wire logic [NCH-1:0]           enc_out_en,
  output logic      [NCH-1:0]           enc_out_data,
  output logic      [NCH-1:0]           enc_out_data_oe,
  // Decoder output link
  input  wire logic [NCH/2-1:0]         dec_out_clk,
  input  wire logic [NCH-1:0]           dec_out_en,
  output logic      [NCH-1:0]           dec_out_data,
  output logic      [NCH-1:0]           dec_out_data_oe
);

  typedef struct packed {
    logic                    sync_s1;
    logic                    sync_s2;
    logic [NCH-1:0][1:0]     mode_s1;
    logic [NCH-1:0][1:0]     mode_s2;
    logic [NCH-1:0][7:0]     enc_op;
    logic [NCH-1:0][7:0]     dec_op;
    logic [NCH-1:0][7:0]     enc_res;
    logic [NCH-1:0][7:0]     dec_res;
  } path_t;

  path_t               s_r;
  path_t               s_nxt;
  logic [NCH-1:0][7:0] enc_word;
  logic [NCH-1:0][7:0] dec_word;
  logic [NCH-1:0]      enc_done;
  logic [NCH-1:0]      dec_done;

  // Stand-in coder: compress 8-bit PCM to a 4-bit code
  function automatic logic [7:0] enc_calc(input logic [7:0] pcm);
    enc_calc = {4'h0, pcm[7:4]};
  endfunction : enc_calc

  // Stand-in decoder: expand a 4-bit code to 8-bit PCM
  function automatic logic [7:0] dec_calc(input logic [7:0] code);
    dec_calc = {code[3:0], 4'h0};
  endfunction : dec_calc

  // Word length per input port; pass-through and 64k loop-back widen the 32 kbps sides to 8 bits
  function automatic logic is_wide(input logic [1:0] m, input logic fixed8);
    is_wide = fixed8 || (m == MODE_THRU64) || (m == MODE_LOOP64);
  endfunction : is_wide

  // Operand capture and result update, one channel at a time
  always_comb begin
    s_nxt         = s_r;
    s_nxt.sync_s1 = sync_mode;
    s_nxt.sync_s2 = s_r.sync_s1;
    s_nxt.mode_s1 = chan_mode;
    s_nxt.mode_s2 = s_r.mode_s1;
    for (int c = 0; c < NCH; c++) begin
      // Encoder-side start pulse: result from the previous operand
      if (enc_done[c]) begin
        s_nxt.enc_op[c] = enc_word[c];
        if (s_r.mode_s2[c] == MODE_NORMAL) begin
          s_nxt.enc_res[c] = enc_calc(s_r.enc_op[c]);
        end else if (s_r.mode_s2[c] == MODE_THRU64) begin
          s_nxt.enc_res[c] = s_r.enc_op[c];
        end else if (s_r.mode_s2[c] == MODE_LOOP64) begin
          s_nxt.dec_res[c] = s_r.enc_op[c];
        end
      end
      // Decoder-side start pulse
      if (dec_done[c]) begin
        s_nxt.dec_op[c] = dec_word[c];
        if (s_r.mode_s2[c] == MODE_NORMAL) begin
          s_nxt.dec_res[c] = dec_calc(s_r.dec_op[c]);
        end else if (s_r.mode_s2[c] == MODE_THRU64) begin
          s_nxt.dec_res[c] = s_r.dec_op[c];
        end else if (s_r.mode_s2[c] == MODE_LOOP32) begin
          s_nxt.enc_res[c] = {4'h0, s_r.dec_op[c][3:0]};
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Four independent ports per channel, clocks shared by channel pairs
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    serial_port #(.IS_OUT(1'b0)) u_enc_in (
      .clk       (clk),
      .rst_n     (rst_n),
      .sync_mode (s_r.sync_s2),
      .wide      (is_wide(s_r.mode_s2[c], 1'b1)),
      .load_word (8'h00),
      .sclk_pin  (enc_in_clk[c/2]),
      .en_pin    (enc_in_en[c]),
      .din_pin   (enc_in_data[c]),
      .word      (enc_word[c]),
      .done      (enc_done[c]),
      .dout      (),
      .doe       ()
    );
    serial_port #(.IS_OUT(1'b0)) u_dec_in (
      .clk       (clk),
      .rst_n     (rst_n),
      .sync_mode (s_r.sync_s2),
      .wide      (is_wide(s_r.mode_s2[c], 1'b0)),
      .load_word (8'h00),
      .sclk_pin  (dec_in_clk[c/2]),
      .en_pin    (dec_in_en[c]),
      .din_pin   (dec_in_data[c]),
      .word      (dec_word[c]),
      .done      (dec_done[c]),
      .dout      (),
      .doe       ()
    );
    serial_port #(.IS_OUT(1'b1)) u_enc_out (
      .clk       (clk),
      .rst_n     (rst_n),
      .sync_mode (s_r.sync_s2),
      .wide      (s_r.mode_s2[c] == MODE_THRU64),
      .load_word (s_r.enc_res[c]),
      .sclk_pin  (enc_out_clk[c/2]),
      .en_pin    (enc_out_en[c]),
      .din_pin   (1'b0),
      .word      (),
      .done      (),
      .dout      (enc_out_data[c]),
      .doe       (enc_out_data_oe[c])
    );
    serial_port #(.IS_OUT(1'b1)) u_dec_out (
      .clk       (clk),
      .rst_n     (rst_n),
      .sync_mode (s_r.sync_s2),
      .wide      (1'b1),
      .load_word (s_r.dec_res[c]),
      .sclk_pin  (dec_out_clk[c/2]),
      .en_pin    (dec_out_en[c]),
      .din_pin   (1'b0),
      .word      (),
      .done      (),
      .dout      (dec_out_data[c]),
      .doe       (dec_out_data_oe[c])
    );

    AST_OPERAND_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      enc_done[c] |=> s_r.enc_op[c] == $past(enc_word[c]))
      else $error("operand not captured on start pulse");
    AST_THRU_COPY: assert property (@(posedge clk) disable iff (!rst_n)
      (enc_done[c] && s_r.mode_s2[c] == MODE_THRU64) |=> s_r.enc_res[c] == $past(s_r.enc_op[c]))
      else $error("pass-through altered the word");
    AST_LOOP64: assert property (@(posedge clk) disable iff (!rst_n)
      (enc_done[c] && s_r.mode_s2[c] == MODE_LOOP64) |=> s_r.dec_res[c] == $past(s_r.enc_op[c]))
      else $error("64k loop-back did not reach decoder output");
    AST_LOOP32: assert property (@(posedge clk) disable iff (!rst_n)
      (dec_done[c] && s_r.mode_s2[c] == MODE_LOOP32) |=> s_r.enc_res[c][3:0] == $past(s_r.dec_op[c][3:0]))
      else $error("32k loop-back did not reach encoder output");

    // Operands and results move only on start pulses
    AST_OPERAND_DEC: assert property (@(posedge clk) disable iff (!rst_n)
      dec_done[c] |=> s_r.dec_op[c] == $past(dec_word[c]))
      else $error("decoder operand not captured on start pulse");
    AST_OPERAND_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (!enc_done[c] && !dec_done[c]) |=> ($stable(s_r.enc_op[c]) && $stable(s_r.dec_op[c])))
      else $error("operand changed without a start pulse");
    AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (!enc_done[c] && !dec_done[c]) |=> ($stable(s_r.enc_res[c]) && $stable(s_r.dec_res[c])))
      else $error("result changed without a start pulse");
    // Result contents per mode
    AST_NORMAL_ENC: assert property (@(posedge clk) disable iff (!rst_n)
      (enc_done[c] && s_r.mode_s2[c] == MODE_NORMAL) |=> s_r.enc_res[c] == {4'h0, $past(s_r.enc_op[c][7:4])})
      else $error("encoder result not taken from previous operand");
    AST_NORMAL_DEC: assert property (@(posedge clk) disable iff (!rst_n)
      (dec_done[c] && s_r.mode_s2[c] == MODE_NORMAL) |=> s_r.dec_res[c] == {$past(s_r.dec_op[c][3:0]), 4'h0})
      else $error("decoder result not taken from previous operand");
    AST_THRU_DEC: assert property (@(posedge clk) disable iff (!rst_n)
      (dec_done[c] && s_r.mode_s2[c] == MODE_THRU64) |=> s_r.dec_res[c] == $past(s_r.dec_op[c]))
      else $error("decoder pass-through altered the word");
    AST_LOOP32_NIBBLE: assert property (@(posedge clk) disable iff (!rst_n)
      (dec_done[c] && s_r.mode_s2[c] == MODE_LOOP32) |=> s_r.enc_res[c][7:4] == 4'h0)
      else $error("32k loop-back result has stray high bits");
    AST_LOOP64_DEC_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      (dec_done[c] && !enc_done[c] && s_r.mode_s2[c] == MODE_LOOP64) |=> $stable(s_r.dec_res[c]))
      else $error("decoder input disturbed 64k loop-back result");
  end

endmodule : adpcm_serial_data_delay_path

/* link_partner.sv */
`timescale 1ns/1ps

module link_partner
  import transcoder_pkg::*;
(
  // Words to send and word lengths
  input  wire logic [NCH-1:0][7:0] ew,
  input  wire logic [NCH-1:0][7:0] dw,
  input  wire logic [NCH-1:0]      dshort,
  input  wire logic [NCH-1:0]      eshort,
  // Serial outputs of the transcoder
  input  wire logic [NCH-1:0]      eod,
  input  wire logic [NCH-1:0]      dod,
  // Link clock, enable and input data
  output logic      [NCH/2-1:0]    lclk,
  output logic      [NCH-1:0]      en,
  output logic      [NCH-1:0]      eid,
  output logic      [NCH-1:0]      did,
  // Words collected in the last frame
  output logic      [NCH-1:0][7:0] ecap,
  output logic      [NCH-1:0][7:0] dcap
);
  // Idle link: clock stands still
  initial begin
    lclk = '0;
    en = '0;
    eid = '0;
    did = '1;
  end

  // One frame on all links; en1 gives a one-bit enable, late delays the data a bit
  task automatic frame(input bit en1, input bit late);
    int b;
    int li;
    int lo;
    ecap = '0;
    dcap = '0;
    en = '1;
    #160;
    for (int k = 0; k < 10; k++) begin
      lclk = '1;
      b = k - int'(late);
      // Data changes with rises, MSB first; released lines toggle
      for (int c = 0; c < NCH; c++) begin
        li = dshort[c] ? 4 : 8;
        eid[c] = (b >= 0 && b < 8) ? ew[c][7-b] : ~eid[c];
        did[c] = (b >= 0 && b < li) ? dw[c][li-1-b] : ~did[c];
      end
      #160;
      lclk = '0;
      // Enable moves on falls so it stands still around every rise
      en = (k == 0 && !en1) ? '1 : '0;  // Enable width picks frame type
      #140;
      // Output bits sampled late in their link period
      for (int c = 0; c < NCH; c++) begin
        lo = eshort[c] ? 4 : 8;
        if (b >= 0 && b < lo)
          ecap[c][lo-1-b] = eod[c];
        if (b >= 0 && b < 8)
          dcap[c][7-b] = dod[c];
      end
      #20;
    end
    #320;
  endtask : frame

endmodule : link_partner

/* adpcm_serial_data_delay_path_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("FAIL %0t got %h exp %h", $time, a, e); end end

module adpcm_serial_data_delay_path_tb
  import transcoder_pkg::*;
;
  logic                clk;
  logic                rst_n;
  logic                sync_mode;
  logic [NCH-1:0][1:0] chan_mode;
  logic [NCH-1:0][7:0] ew;
  logic [NCH-1:0][7:0] dw;
  logic [NCH-1:0][7:0] he [4];
  logic [NCH-1:0][7:0] hd [4];
  logic [NCH-1:0][7:0] ecap;
  logic [NCH-1:0][7:0] dcap;
  logic [NCH-1:0]      dshort;
  logic [NCH-1:0]      eshort;
  logic [NCH/2-1:0]    lclk;
  logic [NCH-1:0]      en, eid, did, eod, dod, eoe, doe;
  logic [NCH-1:0]      oe_seen;
  int                  error_cnt;
  int                  compares;

  // Clock
  always #20 clk = ~clk;

  // Remembers which channels drove both output pins since reset
  always @(posedge clk) oe_seen <= rst_n ? (oe_seen | (eoe & doe)) : '0;

  // Word lengths follow each channel's mode
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      dshort[c] = chan_mode[c] inside {MODE_NORMAL, MODE_LOOP32};
      eshort[c] = chan_mode[c] != MODE_THRU64;
    end
  end

  adpcm_serial_data_delay_path dut (
    .clk(clk), .rst_n(rst_n), .sync_mode(sync_mode), .chan_mode(chan_mode),
    .enc_in_clk(lclk), .enc_in_en(en), .enc_in_data(eid),
    .dec_in_clk(lclk), .dec_in_en(en), .dec_in_data(did),
    .enc_out_clk(lclk), .enc_out_en(en), .enc_out_data(eod), .enc_out_data_oe(eoe),
    .dec_out_clk(lclk), .dec_out_en(en), .dec_out_data(dod), .dec_out_data_oe(doe)
  );

  link_partner lp (
    .ew(ew), .dw(dw), .dshort(dshort), .eshort(eshort), .eod(eod), .dod(dod),
    .lclk(lclk), .en(en), .eid(eid), .did(did), .ecap(ecap), .dcap(dcap)
  );

  // Output frame carries the words sent two frames earlier
  task automatic check_frame(input logic [NCH-1:0][7:0] e, input logic [NCH-1:0][7:0] d);
    for (int c = 0; c < NCH; c++) begin
      case (chan_mode[c])
        MODE_NORMAL: begin
          `CHK(ecap[c], {4'h0, e[c][7:4]})
          `CHK(dcap[c], {d[c][3:0], 4'h0})
        end
        MODE_THRU64: begin
          `CHK(ecap[c], e[c])
          `CHK(dcap[c], d[c])
        end
        MODE_LOOP64: `CHK(dcap[c], e[c])
        default: `CHK(ecap[c], {4'h0, d[c][3:0]})
      endcase
    end
  endtask : check_frame

  // Reset, then four aligned frames with fresh words per channel
  task automatic run_case(input bit en1, input bit late, input bit sm);
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    sync_mode = sm;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    `CHK(eoe | doe, 4'h0)
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < NCH; c++) begin
        ew[c] = 8'(8'h3c + f * 8'h47 + c * 8'h15);
        dw[c] = 8'(8'ha5 + f * 8'h3b + c * 8'h29);
      end
      he[f] = ew;
      hd[f] = dw;
      lp.frame(en1, late);
      `CHK(eoe | doe, 4'h0)
      if (f == 0)
        `CHK(oe_seen, 4'hf)
      if (f >= 2)
        check_frame(he[f-2], hd[f-2]);
    end
  endtask : run_case

  // Long frames: two-bit enable, data on the enable rise
  task automatic t_long;
    run_case(1'b0, 1'b0, 1'b0);
  endtask : t_long

  // Short frames: one-bit enable, data one bit later
  task automatic t_short;
    run_case(1'b1, 1'b1, 1'b0);
  endtask : t_short

  // Synchronous mode: one-bit enable, data right after the rise
  task automatic t_sync;
    run_case(1'b1, 1'b0, 1'b1);
  endtask : t_sync

  // Verdict and end of run
  task automatic results;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Main sequence; every channel in a different mode
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sync_mode = 1'b0;
    chan_mode = {MODE_LOOP32, MODE_LOOP64, MODE_THRU64, MODE_NORMAL};
    ew = '0;
    dw = '0;
    error_cnt = 0;
    compares = 0;
    t_long();
    t_short();
    t_sync();
    results();
  end

  // Watchdog against a hang
  initial begin
    #200_000;
    error_cnt++;
    results();
  end

endmodule : adpcm_serial_data_delay_path_tb
